// [hdl/otp_fuse_bank_manager.sv]
// fuse array, bank scan after reset, programming engine and Avalon-MM register slave
// assumes a well-behaved Avalon master; srst also stands for power-on, restoring the factory image
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module otp_fuse_bank_manager #(
  parameter logic [47:0] FACTORY_ADDR = 48'h0000_0000_0000,
  parameter logic HAS_FACTORY_ADDR = 1'b0,
  parameter logic [3:0] FACTORY_QGAIN = 4'h8,
  parameter logic [3:0] FACTORY_QPHASE = 4'h8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic host_interrupt_request_low
);
  logic [otp_fuse_pkg::BANK_BITS-1:0] fuse [otp_fuse_pkg::NUM_BANKS];
  logic [otp_fuse_pkg::NUM_BANKS-1:0] bank_ok;
  logic [otp_fuse_pkg::BANK_BITS-1:0] factory_image;
  otp_fuse_pkg::fuse_state_e state;
  logic [2:0] scan_idx;
  logic [2:0] active_bank;
  logic active_valid;
  logic [3:0] burn_cnt;
  logic burn_fire;
  logic [2:0] prog_bank;
  logic [1:0] prog_word;
  logic [31:0] prog_data;
  logic [2:0] rd_bank;
  logic [1:0] rd_word;
  logic legacy_fw;
  logic prog_err;
  logic irq_req;
  logic [31:0] be_mask;
  logic [31:0] wr_val;
  logic take;
  logic take_wr;
  logic accept;
  logic [31:0] next_readdata;
  logic [otp_fuse_pkg::BANK_BITS-1:0] act;
  logic [otp_fuse_pkg::BANK_BITS-1:0] burn_mask;
  logic [31:0] guarded_data;
  logic [47:0] sta_addr;
  logic [47:0] sec_addr;
  logic [7:0] adc_trim;
  logic [7:0] freq_trim;
  logic [3:0] qgain;
  logic [3:0] qphase;

  // factory image of bank two
  always_comb begin
    factory_image = '0;
    factory_image[otp_fuse_pkg::USED_BIT] = 1'b1;
    factory_image[otp_fuse_pkg::QGAIN_USED_BIT] = 1'b1;
    factory_image[otp_fuse_pkg::QPHASE_USED_BIT] = 1'b1;
    factory_image[otp_fuse_pkg::QGAIN_LSB +: otp_fuse_pkg::QGAIN_W] = FACTORY_QGAIN;
    factory_image[otp_fuse_pkg::QPHASE_LSB +: otp_fuse_pkg::QPHASE_W] = FACTORY_QPHASE;
    factory_image[otp_fuse_pkg::ADDR_USED_BIT] = HAS_FACTORY_ADDR;
    factory_image[otp_fuse_pkg::ADDR_LSB +: otp_fuse_pkg::ADDR_W] = HAS_FACTORY_ADDR ? FACTORY_ADDR : 48'h0;
  end

  // banks 0 and 1 only ever take their retired flag, whatever the agent asks
  always_comb begin
    guarded_data = prog_data;
    if (prog_bank < otp_fuse_pkg::FIRST_PROG_BANK) begin
      guarded_data = prog_word == 2'h0 ? (prog_data & (32'h1 << otp_fuse_pkg::RETIRED_BIT)) : 32'h0;
    end
    burn_mask = {96'h0, guarded_data} << {prog_word, 5'h00};
  end

  assign burn_fire = (state == otp_fuse_pkg::st_burn) && (burn_cnt == otp_fuse_pkg::BURN_CYCLES - 4'h1);

  // fuse bits only ever go from 0 to 1, one bank at a time
  for (genvar b = 0; b < otp_fuse_pkg::NUM_BANKS; b++) begin : g_bank
    always_ff @(posedge clk) begin
      if (srst) begin
        fuse[b] <= (b == otp_fuse_pkg::FACTORY_BANK) ? factory_image : '0;
      end else if (burn_fire && prog_bank == 3'(b)) begin
        fuse[b] <= fuse[b] | burn_mask;
      end
    end
    assign bank_ok[b] = fuse[b][otp_fuse_pkg::USED_BIT] & ~fuse[b][otp_fuse_pkg::RETIRED_BIT];
    a_bank_sticky: assert property (@(posedge clk) disable iff (srst)
      !$past(srst) |-> ((fuse[b] & $past(fuse[b])) == $past(fuse[b])))
      else $error("fuse bit cleared");
    a_bank_isolate: assert property (@(posedge clk) disable iff (srst)
      (burn_fire && prog_bank != 3'(b)) |=> $stable(fuse[b]))
      else $error("burn disturbed another bank");
  end

  // scan from the top bank down; the first good one wins
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= otp_fuse_pkg::st_scan;
      scan_idx <= otp_fuse_pkg::LAST_BANK;
      active_bank <= 3'h0;
      active_valid <= 1'b0;
      burn_cnt <= 4'h0;
    end else begin
      case (state)
        otp_fuse_pkg::st_scan: begin
          if (bank_ok[scan_idx]) begin
            active_bank <= scan_idx;
            active_valid <= 1'b1;
            state <= otp_fuse_pkg::st_ready;
          end else if (scan_idx == 3'h0) begin
            // no stale bank number left in status once every bank is gone
            active_bank <= 3'h0;
            active_valid <= 1'b0;
            state <= otp_fuse_pkg::st_ready;
          end else begin
            scan_idx <= scan_idx - 3'h1;
          end
        end
        otp_fuse_pkg::st_ready: begin
          if (take_wr && avs_address == otp_fuse_pkg::REG_CTRL && avs_byteenable[0]) begin
            if (avs_writedata[otp_fuse_pkg::CTRL_BURN_BIT]) begin
              burn_cnt <= 4'h0;
              state <= otp_fuse_pkg::st_burn;
            end else if (avs_writedata[otp_fuse_pkg::CTRL_RESCAN_BIT]) begin
              scan_idx <= otp_fuse_pkg::LAST_BANK;
              state <= otp_fuse_pkg::st_scan;
            end
          end
        end
        otp_fuse_pkg::st_burn: begin
          burn_cnt <= burn_cnt + 4'h1;
          if (burn_fire) begin
            scan_idx <= otp_fuse_pkg::LAST_BANK;
            state <= otp_fuse_pkg::st_scan;
          end
        end
        default: begin
          scan_idx <= otp_fuse_pkg::LAST_BANK;
          state <= otp_fuse_pkg::st_scan;
        end
      endcase
    end
  end

  localparam int SCAN_LIMIT = otp_fuse_pkg::SCAN_MAX_CYCLES;
  a_scan_bound: assert property (@(posedge clk) disable iff (srst)
    $past(srst) |-> ##[1:SCAN_LIMIT] (state == otp_fuse_pkg::st_ready))
    else $error("bank scan did not finish");
  a_active_top: assert property (@(posedge clk) disable iff (srst)
    (state == otp_fuse_pkg::st_ready && active_valid) |->
      (bank_ok[active_bank] && ((bank_ok >> (active_bank + 3'h1)) == 6'h00)))
    else $error("active bank is not the highest good bank");
  a_none_valid: assert property (@(posedge clk) disable iff (srst)
    (state == otp_fuse_pkg::st_ready && !active_valid) |-> (bank_ok == 6'h00))
    else $error("good bank missed by scan");
  a_low_guard: assert property (@(posedge clk) disable iff (srst)
    ((fuse[0] | fuse[1]) & ~(128'h1 << otp_fuse_pkg::RETIRED_BIT)) == '0)
    else $error("parameter bits burned in bank 0 or 1");
  a_factory_trim: assert property (@(posedge clk)
    $fell(srst) |-> (fuse[2][otp_fuse_pkg::QGAIN_USED_BIT] && fuse[2][otp_fuse_pkg::QPHASE_USED_BIT]
      && fuse[2][otp_fuse_pkg::QGAIN_LSB +: otp_fuse_pkg::QGAIN_W] == FACTORY_QGAIN))
    else $error("factory trims missing in bank two");
  a_factory_addr: assert property (@(posedge clk)
    $fell(srst) |-> (fuse[2][otp_fuse_pkg::ADDR_USED_BIT] == HAS_FACTORY_ADDR))
    else $error("factory address flag wrong in bank two");

  // fields of the active bank, each shown only once its own used bit is burned
  assign act = active_valid ? fuse[active_bank] : '0;
  assign sta_addr = act[otp_fuse_pkg::ADDR_USED_BIT] ? act[otp_fuse_pkg::ADDR_LSB +: otp_fuse_pkg::ADDR_W] : 48'h0;
  assign sec_addr = sta_addr + 48'h1;
  assign adc_trim = act[otp_fuse_pkg::ADC_USED_BIT] ? act[otp_fuse_pkg::ADC_LSB +: otp_fuse_pkg::ADC_W] : 8'h00;
  assign freq_trim = act[otp_fuse_pkg::FREQ_USED_BIT] ? act[otp_fuse_pkg::FREQ_LSB +: otp_fuse_pkg::FREQ_W] : 8'h00;
  // legacy firmware treats the quadrature trims as reserved
  assign qgain = (act[otp_fuse_pkg::QGAIN_USED_BIT] && !legacy_fw) ?
    act[otp_fuse_pkg::QGAIN_LSB +: otp_fuse_pkg::QGAIN_W] : 4'h0;
  assign qphase = (act[otp_fuse_pkg::QPHASE_USED_BIT] && !legacy_fw) ?
    act[otp_fuse_pkg::QPHASE_LSB +: otp_fuse_pkg::QPHASE_W] : 4'h0;

  a_sec_addr: assert property (@(posedge clk) disable iff (srst)
    (avs_read && !avs_waitrequest && avs_address == otp_fuse_pkg::REG_SEC_LO) |->
      (avs_readdata == $past(sta_addr[31:0]) + 32'h1))
    else $error("secondary address is not station address plus one");
  a_legacy_trim: assert property (@(posedge clk) disable iff (srst)
    (avs_read && !avs_waitrequest && avs_address == otp_fuse_pkg::REG_TRIM && legacy_fw) |->
      (avs_readdata[23:16] == 8'h00))
    else $error("quadrature trims visible to legacy firmware");

  // bus slave: one wait cycle, reads stall while a scan or a burn is running
  assign accept = avs_write || (avs_read && state == otp_fuse_pkg::st_ready);
  assign take = !avs_waitrequest && (avs_read || avs_write);
  assign take_wr = take && avs_write;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      be_mask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_waitrequest && accept) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    next_readdata = otp_fuse_pkg::RESET_WORD;
    case (avs_address)
      otp_fuse_pkg::REG_PROG_ADDR: next_readdata = {27'h0, prog_word, prog_bank};
      otp_fuse_pkg::REG_PROG_DATA: next_readdata = prog_data;
      otp_fuse_pkg::REG_READ_ADDR: next_readdata = {27'h0, rd_word, rd_bank};
      otp_fuse_pkg::REG_READ_DATA: next_readdata = (rd_bank <= otp_fuse_pkg::LAST_BANK) ?
        fuse[rd_bank][{rd_word, 5'h00} +: 32] : 32'h0;
      otp_fuse_pkg::REG_STATUS: begin
        next_readdata[otp_fuse_pkg::STAT_BUSY_BIT] = state != otp_fuse_pkg::st_ready;
        next_readdata[otp_fuse_pkg::STAT_VALID_BIT] = active_valid;
        next_readdata[otp_fuse_pkg::STAT_BANK_LSB +: 3] = active_bank;
        next_readdata[otp_fuse_pkg::STAT_ERR_BIT] = prog_err;
      end
      otp_fuse_pkg::REG_ADDR_LO: next_readdata = sta_addr[31:0];
      otp_fuse_pkg::REG_ADDR_HI: next_readdata = {16'h0, sta_addr[47:32]};
      otp_fuse_pkg::REG_SEC_LO: next_readdata = sec_addr[31:0];
      otp_fuse_pkg::REG_SEC_HI: next_readdata = {16'h0, sec_addr[47:32]};
      otp_fuse_pkg::REG_TRIM: next_readdata = {8'h0, qphase, qgain, freq_trim, adc_trim};
      otp_fuse_pkg::REG_CFG: next_readdata = {31'h0, legacy_fw};
      otp_fuse_pkg::REG_IRQ: next_readdata = {31'h0, irq_req};
      default: next_readdata = otp_fuse_pkg::RESET_WORD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      avs_readdata <= otp_fuse_pkg::RESET_WORD;
    end else if (avs_waitrequest && avs_read && accept) begin
      avs_readdata <= next_readdata;
    end
  end

  // software-writable registers with byte enables
  assign wr_val = avs_writedata & be_mask;
  always_ff @(posedge clk) begin
    if (srst) begin
      prog_bank <= otp_fuse_pkg::FIRST_PROG_BANK;
      prog_word <= 2'h0;
      prog_data <= otp_fuse_pkg::RESET_WORD;
      rd_bank <= 3'h0;
      rd_word <= 2'h0;
      legacy_fw <= 1'b0;
      irq_req <= 1'b0;
    end else if (take_wr) begin
      case (avs_address)
        otp_fuse_pkg::REG_PROG_ADDR: begin
          if (avs_byteenable[0] && state != otp_fuse_pkg::st_burn) begin
            prog_bank <= wr_val[2:0];
            prog_word <= wr_val[4:3];
          end
        end
        otp_fuse_pkg::REG_PROG_DATA: begin
          if (state != otp_fuse_pkg::st_burn) begin
            prog_data <= (prog_data & ~be_mask) | wr_val;
          end
        end
        otp_fuse_pkg::REG_READ_ADDR: begin
          if (avs_byteenable[0]) begin
            rd_bank <= wr_val[2:0];
            rd_word <= wr_val[4:3];
          end
        end
        otp_fuse_pkg::REG_CFG: if (avs_byteenable[0]) legacy_fw <= wr_val[0];
        otp_fuse_pkg::REG_IRQ: if (avs_byteenable[0]) irq_req <= wr_val[0];
        default: begin
        end
      endcase
    end
  end

  // error: request to burn parameter bits into bank 0/1, or a bad bank; set wins over clear
  always_ff @(posedge clk) begin
    if (srst) begin
      prog_err <= 1'b0;
    end else if (burn_fire && (prog_bank > otp_fuse_pkg::LAST_BANK || guarded_data != prog_data)) begin
      prog_err <= 1'b1;
    end else if (take_wr && avs_address == otp_fuse_pkg::REG_STATUS && avs_writedata[otp_fuse_pkg::STAT_ERR_BIT]
                 && avs_byteenable[1]) begin
      prog_err <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      host_interrupt_request_low <= 1'b1;
    end else begin
      host_interrupt_request_low <= ~irq_req;
    end
  end

  a_irq_follow: assert property (@(posedge clk) disable iff (srst)
    $rose(irq_req) |=> !host_interrupt_request_low)
    else $error("interrupt request pin did not assert");
endmodule : otp_fuse_bank_manager

// [common/otp_fuse_pkg.sv]
// constants for the one-time-programmable fuse bank manager
// assumes a single 25 MHz clock domain and an Avalon-MM register slave with byte addresses
package otp_fuse_pkg;
  localparam int NUM_BANKS = 6;
  localparam int BANK_BITS = 128;
  localparam int FIXED_BITS = 80;
  localparam int WORDS_PER_BANK = 4;
  // bank field layout, identical in every bank
  localparam int USED_BIT = 0;
  localparam int RETIRED_BIT = 1;
  localparam int ADDR_USED_BIT = 2;
  localparam int ADC_USED_BIT = 3;
  localparam int FREQ_USED_BIT = 4;
  localparam int QGAIN_USED_BIT = 5;
  localparam int QPHASE_USED_BIT = 6;
  localparam int ADDR_LSB = 8;
  localparam int ADDR_W = 48;
  localparam int ADC_LSB = 56;
  localparam int ADC_W = 8;
  localparam int FREQ_LSB = 64;
  localparam int FREQ_W = 8;
  localparam int QGAIN_LSB = 72;
  localparam int QGAIN_W = 4;
  localparam int QPHASE_LSB = 76;
  localparam int QPHASE_W = 4;
  localparam logic [2:0] FACTORY_BANK = 3'h2;
  localparam logic [2:0] LAST_BANK = 3'h5;
  localparam logic [2:0] FIRST_PROG_BANK = 3'h2;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PROG_ADDR = 8'h04;
  localparam logic [7:0] REG_PROG_DATA = 8'h08;
  localparam logic [7:0] REG_READ_ADDR = 8'h0c;
  localparam logic [7:0] REG_READ_DATA = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_ADDR_LO = 8'h18;
  localparam logic [7:0] REG_ADDR_HI = 8'h1c;
  localparam logic [7:0] REG_SEC_LO = 8'h20;
  localparam logic [7:0] REG_SEC_HI = 8'h24;
  localparam logic [7:0] REG_TRIM = 8'h28;
  localparam logic [7:0] REG_CFG = 8'h2c;
  localparam logic [7:0] REG_IRQ = 8'h30;
  // control and status bit positions
  localparam int CTRL_BURN_BIT = 0;
  localparam int CTRL_RESCAN_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_BANK_LSB = 4;
  localparam int STAT_ERR_BIT = 8;
  // values after reset and cycle counts
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [3:0] BURN_CYCLES = 4'h4;
  localparam int SCAN_MAX_CYCLES = 7;
  typedef enum logic [2:0] {
    st_scan = 3'b001,
    st_ready = 3'b010,
    st_burn = 3'b100
  } fuse_state_e;
endpackage : otp_fuse_pkg

// [tb/fuse_agent.sv]
// avalon-mm master standing in for the on-chip processor and the fuse programming agent
// assumes one clock; each request starts at the first edge after its task is entered
`timescale 1ns/1ps
module fuse_agent (
  input wire logic clk,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic host_interrupt_request_low,
  output logic irq_active,
  output int timeouts
);
  assign irq_active = ~host_interrupt_request_low;
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    timeouts = 0;
  end
  // holds the request until waitrequest is sampled low; bounded so a stuck slave cannot hang the run
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    bit done;
    n = 0;
    done = 1'b0;
    q = 32'h0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    while (!done && n < 300) begin
      @(posedge clk);
      n++;
      if (avs_waitrequest === 1'b0) begin
        done = 1'b1;
        q = avs_readdata;
      end
    end
    if (!done) timeouts++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~d;
  endtask : xfer
  task automatic burn(input logic [2:0] b, input logic [1:0] w, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, otp_fuse_pkg::REG_PROG_ADDR, {27'h0, w, b}, q);
    xfer(1'b1, otp_fuse_pkg::REG_PROG_DATA, d, q);
    xfer(1'b1, otp_fuse_pkg::REG_CTRL, 32'h1, q);
    // status read stalls until burn and rescan finish
    xfer(1'b0, otp_fuse_pkg::REG_STATUS, 32'h0, q);
  endtask : burn
  // new_b is never 0 or 1: parameters only go to banks from two upward
  task automatic fill(input logic [2:0] old_b, input logic [2:0] new_b, input logic [31:0] w0, input logic [31:0] w1,
                      input logic [31:0] w2, input logic [31:0] w3);
    burn(old_b, 2'h0, 32'h2);
    burn(new_b, 2'h0, w0);
    burn(new_b, 2'h1, w1);
    burn(new_b, 2'h2, w2);
    burn(new_b, 2'h3, w3);
  endtask : fill
  task automatic validate(input logic [2:0] b);
    burn(b, 2'h0, 32'h1);
  endtask : validate
endmodule : fuse_agent

// [tb/otp_fuse_bank_manager_tb.sv]
// self-checking bench: factory image, bank updates, legacy trims, interrupt pin, guarded banks
// assumes the fuse_agent master model and a factory station address in the device
`timescale 1ns/1ps
module otp_fuse_bank_manager_tb;
  localparam logic [47:0] F_ADDR = 48'h0a0b_0c0d_0e0f;
  localparam logic [3:0] F_QG = 4'h3;
  localparam logic [3:0] F_QP = 4'hc;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, irq_low, irq_active;
  logic [31:0] avs_writedata, avs_readdata, q, r, g, pw0;
  logic [3:0] avs_byteenable, qg, qp;
  logic [7:0] adc, frq;
  logic [47:0] a, s;
  logic [2:0] bb;
  logic [31:0] seed = 32'h0000_e0b3;
  int timeouts;
  int err_total = 0;
  int checks_done = 0;
  always #20 clk = ~clk;
  otp_fuse_bank_manager #(.FACTORY_ADDR(F_ADDR), .HAS_FACTORY_ADDR(1'b1), .FACTORY_QGAIN(F_QG),
    .FACTORY_QPHASE(F_QP)) u_dut (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .host_interrupt_request_low(irq_low));
  fuse_agent u_agent (.clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .host_interrupt_request_low(irq_low), .irq_active(irq_active),
    .timeouts(timeouts));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t word got %h expected %h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t pin got %b expected %b", $time, got, exp);
    end
  endtask : check_bit
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    u_agent.xfer(1'b0, ad, 32'h0, q);
    check_word(q, exp);
  endtask : rd
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    u_agent.xfer(1'b1, ad, d, q);
  endtask : wr
  task automatic raw(input logic [2:0] b, input logic [1:0] w, input logic [31:0] exp);
    wr(otp_fuse_pkg::REG_READ_ADDR, {27'h0, w, b});
    rd(otp_fuse_pkg::REG_READ_DATA, exp);
  endtask : raw
  // a stuck handshake ends the run here rather than hanging it
  always @(posedge clk) begin
    if (timeouts != 0) begin
      err_total++;
      $display("ERROR t=%0t bus handshake timed out", $time);
      final_report;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    s = F_ADDR + 48'h1;
    rd(otp_fuse_pkg::REG_STATUS, 32'h22);
    rd(otp_fuse_pkg::REG_TRIM, {8'h0, F_QP, F_QG, 16'h0});
    rd(otp_fuse_pkg::REG_ADDR_LO, F_ADDR[31:0]);
    rd(otp_fuse_pkg::REG_SEC_HI, {16'h0, s[47:32]});
    raw(3'h2, 2'h0, {F_ADDR[23:0], 8'h65});
    raw(3'h2, 2'h2, {16'h0, F_QP, F_QG, 8'h0});
    raw(3'h6, 2'h0, 32'h0);
    rd(8'h3c, 32'h0);
    $display("test factory done");
    pw0 = {F_ADDR[23:0], 8'h65};
    for (int b = 3; b <= 5; b++) begin
      bb = b[2:0];
      r = xs();
      g = xs();
      a = (b == 5) ? 48'hffff_ffff_ffff : {r[15:0], xs()};
      {qp, qg, frq, adc} = r[23:0];
      u_agent.fill(bb - 3'h1, bb, {a[23:0], 8'h7c}, {adc, a[47:24]}, {g[31:16], qp, qg, frq}, g);
      rd(otp_fuse_pkg::REG_STATUS, 32'h0);
      u_agent.validate(bb);
      rd(otp_fuse_pkg::REG_STATUS, {25'h0, bb, 4'h2});
      rd(otp_fuse_pkg::REG_ADDR_LO, a[31:0]);
      rd(otp_fuse_pkg::REG_ADDR_HI, {16'h0, a[47:32]});
      s = a + 48'h1;
      rd(otp_fuse_pkg::REG_SEC_LO, s[31:0]);
      rd(otp_fuse_pkg::REG_SEC_HI, {16'h0, s[47:32]});
      rd(otp_fuse_pkg::REG_TRIM, {8'h0, qp, qg, frq, adc});
      raw(bb, 2'h3, g);
      raw(bb - 3'h1, 2'h0, pw0 | 32'h2);
      if (b < 5) raw(bb + 3'h1, 2'h0, 32'h0);
      pw0 = {a[23:0], 8'h7d};
      $display("test update bank %0d done", b);
    end
    wr(otp_fuse_pkg::REG_CFG, 32'h1);
    rd(otp_fuse_pkg::REG_TRIM, {16'h0, frq, adc});
    wr(otp_fuse_pkg::REG_CFG, 32'h0);
    $display("test legacy done");
    wr(otp_fuse_pkg::REG_IRQ, 32'h1);
    repeat (2) @(posedge clk);
    check_bit(irq_low, 1'b0);
    check_bit(irq_active, 1'b1);
    wr(otp_fuse_pkg::REG_IRQ, 32'h0);
    repeat (2) @(posedge clk);
    check_bit(irq_low, 1'b1);
    check_bit(irq_active, 1'b0);
    $display("test irq done");
    u_agent.burn(3'h1, 2'h0, 32'h2);
    raw(3'h1, 2'h0, 32'h2);
    rd(otp_fuse_pkg::REG_STATUS, 32'h52);
    // deliberately breaks the agent's duty: parameter data into bank zero
    u_agent.burn(3'h0, 2'h1, 32'hffff_ffff);
    raw(3'h0, 2'h1, 32'h0);
    rd(otp_fuse_pkg::REG_STATUS, 32'h152);
    wr(otp_fuse_pkg::REG_STATUS, 32'h100);
    rd(otp_fuse_pkg::REG_STATUS, 32'h52);
    $display("test guarded banks done");
    final_report;
  end
endmodule : otp_fuse_bank_manager_tb
